// file: hw/baseband_decim_sigdet_config.v
// What this block does
// - Decimation equals decimation field plus one
// - Interpolation enable per modulation type
// - Output scaled by two to code minus ten, codes above 23 taken as 23
// - Matched filter length is field plus one
// - NCO tune, zero keeps rate, FFh halves
// - Slicer manual bandwidth 1/8 to 1/48
// - Slicer bandwidth scaled 1/2 to 1/16
// - Run mode detector threshold, reset zero
// - Wakeup detector threshold, reset zero
// - Low threshold only in selection 11
// - ASK threshold range 6, 7, 13, 8
// - FSK threshold range 2, 4, 6, 8
// - Low threshold range 2, 4, 6, 8
// - Mode 11 noise valid only above low
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "bbcfg_consts.vh"

module baseband_decim_sigdet_config #(
    parameter SW = 16,
    parameter MF_MAX = 16
) (
    input wire CLK,
    input wire RST_B,
    input wire [`REG_ADDR_W-1:0] ADDR,
    input wire [7:0] WR_DATA,
    input wire WR_STB,
    input wire RD_STB,
    output reg [7:0] RD_DATA,
    input wire [SW-1:0] IN_DATA,
    input wire IN_VALID,
    output wire IN_READY,
    output wire [SW+3:0] OUT_DATA,
    output wire OUT_VALID,
    input wire OUT_READY,
    input wire MODE_ASK,
    input wire WAKEUP,
    input wire [1:0] DETECTOR_SELECTION,
    input wire NOISE_DETECT,
    output reg SIGNAL_DETECT,
    output reg LOW_LEVEL_DETECT,
    output reg NOISE_VALID,
    output reg [10:0] SLICER_BW_DIV
);

    localparam AW = SW + 7;
    localparam [`REG_COUNT*8-1:0] OFFS = `REG_OFFSETS;
    localparam [`REG_COUNT*8-1:0] MASKS = `REG_MASKS;
    localparam [`REG_COUNT*8-1:0] RESETS = `REG_RESETS;

    // ------------
    // Register file
    // ------------
    wire [`REG_COUNT*8-1:0] cfg_flat;
    genvar g;

    // Reserved bits are rebuilt from the reset pattern on each write,
    // so they read back fixed whatever software wrote
    generate
        for (g = 0; g < `REG_COUNT; g = g + 1) begin : regs
            reg [7:0] cfg_r;
            always @(posedge CLK or negedge RST_B) begin
                if (!RST_B) begin
                    cfg_r <= RESETS[g*8 +: 8];
                end else if (WR_STB && ADDR == OFFS[g*8 +: 8]) begin
                    cfg_r <= (WR_DATA & MASKS[g*8 +: 8]) |
                             (RESETS[g*8 +: 8] & ~MASKS[g*8 +: 8]);
                end
            end
            assign cfg_flat[g*8 +: 8] = cfg_r;
        end
    endgenerate

    // Named views of the fields
    wire [7:0] r_pdecf = cfg_flat[`IDX_PDECF*8 +: 8];
    wire [7:0] r_scfsk = cfg_flat[`IDX_SCFSK*8 +: 8];
    wire [7:0] r_scask = cfg_flat[`IDX_SCASK*8 +: 8];
    wire [7:0] r_mfc = cfg_flat[`IDX_MFC*8 +: 8];
    wire [7:0] r_nco = cfg_flat[`IDX_NCO*8 +: 8];
    wire [7:0] r_slc = cfg_flat[`IDX_SLC*8 +: 8];
    wire [7:0] r_rsel = cfg_flat[`IDX_RSEL*8 +: 8];
    wire [6:0] decimation_factor_field = r_pdecf[`DECIM_MSB:0];
    wire fsk_interp_enable = r_scfsk[`INTERP_BIT];
    wire ask_interp_enable = r_scask[`INTERP_BIT];
    wire [4:0] fsk_prescale = r_scfsk[`PRESCALE_MSB:0];
    wire [4:0] ask_prescale = r_scask[`PRESCALE_MSB:0];
    wire [3:0] filter_length_field = r_mfc[`MFL_MSB:0];
    wire [7:0] rate_nco_tune = r_nco;
    wire [2:0] slicer_manual_bw = r_slc[`SLC_BW_MSB:0];
    wire [1:0] slicer_bw_scaling = r_slc[`SLC_SCA_MSB:`SLC_SCA_LSB];
    wire [1:0] ask_range_factor = r_rsel[`ASK_RNG_MSB:`ASK_RNG_LSB];
    wire [1:0] fsk_range_factor = r_rsel[`FSK_RNG_MSB:`FSK_RNG_LSB];
    wire [1:0] low_range_factor = r_rsel[`LOW_RNG_MSB:`LOW_RNG_LSB];

    // ------------
    // Pin synchronisers
    // ------------
    reg [4:0] pin_meta_r;
    reg [4:0] pin_sync_r;

    // Mode pins are asynchronous; only the second stage is read
    always @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            pin_meta_r <= 5'h00;
            pin_sync_r <= 5'h00;
        end else begin
            pin_meta_r <= {NOISE_DETECT, DETECTOR_SELECTION, WAKEUP, MODE_ASK};
            pin_sync_r <= pin_meta_r;
        end
    end

    wire mode_ask = pin_sync_r[0];
    wire wakeup = pin_sync_r[1];
    wire [1:0] detector_selection = pin_sync_r[3:2];
    wire noise_raw = pin_sync_r[4];

    // ------------
    // Scaling helper
    // ------------
    // Power-of-two gain with saturation; codes above the top clamp there
    function [SW-1:0] scale_sat;
        input [AW-1:0] x;
        input [4:0] code;
        reg signed [47:0] w;
        reg [4:0] c;
        begin
            c = (code > `SCALE_MAX) ? `SCALE_MAX : code;
            w = {{(48-AW){x[AW-1]}}, x};
            if (c < `SCALE_UNITY)
                w = w >>> (`SCALE_UNITY - c);
            else
                w = w <<< (c - `SCALE_UNITY);
            if ((&w[47:SW-1]) | ~(|w[47:SW-1]))
                scale_sat = w[SW-1:0];
            else if (w[47])
                scale_sat = {1'b1, {(SW-1){1'b0}}};
            else
                scale_sat = {1'b0, {(SW-1){1'b1}}};
        end
    endfunction

    // ------------
    // Stream control
    // ------------
    reg st_valid_r;
    reg [SW+3:0] st_data_r;
    wire buf_ready;
    wire take;
    wire st_move;

    // One stage feeding the buffer; input stalls only when both are full
    assign st_move = st_valid_r & buf_ready;
    assign IN_READY = ~st_valid_r | buf_ready;
    assign take = IN_VALID & IN_READY;

    // ------------
    // Predecimation
    // ------------
    reg [6:0] dec_cnt_r;
    reg [AW-1:0] dec_acc_r;
    wire [AW-1:0] in_ext = {{7{IN_DATA[SW-1]}}, IN_DATA};
    wire [AW-1:0] dec_sum = dec_acc_r + in_ext;
    wire dump = take & (dec_cnt_r == decimation_factor_field);

    // Accumulate and dump over factor plus one samples
    always @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            dec_cnt_r <= 7'h00;
            dec_acc_r <= {AW{1'b0}};
        end else if (dump) begin
            dec_cnt_r <= 7'h00;
            dec_acc_r <= {AW{1'b0}};
        end else if (take) begin
            dec_cnt_r <= dec_cnt_r + 7'h01;
            dec_acc_r <= dec_sum;
        end
    end

    // Gain and interpolation follow the modulation in use
    wire [4:0] prescale = mode_ask ? ask_prescale : fsk_prescale;
    wire interp_en = mode_ask ? ask_interp_enable : fsk_interp_enable;
    wire [SW-1:0] scaled = scale_sat(dec_sum, prescale);
    reg [SW-1:0] prev_r;
    wire [SW:0] mid_sum = {scaled[SW-1], scaled} + {prev_r[SW-1], prev_r};
    wire [SW-1:0] smp = interp_en ? mid_sum[SW:1] : scaled;

    // Last scaled sample kept as the interpolation partner
    always @(posedge CLK or negedge RST_B) begin
        if (!RST_B)
            prev_r <= {SW{1'b0}};
        else if (dump)
            prev_r <= scaled;
    end

    // ------------
    // Sample rate converter
    // ------------
    reg [8:0] nco_r;
    wire nco_pass = (nco_r < `NCO_WRAP);

    // Passes add the tune word, drops pay back one wrap, so the pass
    // ratio is 256/(256+tune): zero keeps every sample, FFh about half
    always @(posedge CLK or negedge RST_B) begin
        if (!RST_B)
            nco_r <= 9'h000;
        else if (dump) begin
            if (nco_pass)
                nco_r <= nco_r + {1'b0, rate_nco_tune};
            else
                nco_r <= nco_r - `NCO_WRAP;
        end
    end

    wire emit = dump & nco_pass;

    // ------------
    // Matched filter
    // ------------
    wire [4:0] mf_len = {1'b0, filter_length_field} + 5'h01;
    wire [SW*MF_MAX-1:0] taps;
    assign taps[SW-1:0] = smp;

    // History line; tap 0 is the sample arriving now
    generate
        for (g = 1; g < MF_MAX; g = g + 1) begin : hist
            reg [SW-1:0] h_r;
            always @(posedge CLK or negedge RST_B) begin
                if (!RST_B)
                    h_r <= {SW{1'b0}};
                else if (emit)
                    h_r <= taps[(g-1)*SW +: SW];
            end
            assign taps[g*SW +: SW] = h_r;
        end
    endgenerate

    // Moving sum over the programmed length only
    reg [SW+3:0] mf_sum;
    integer k;
    always @* begin
        mf_sum = {(SW+4){1'b0}};
        for (k = 0; k < MF_MAX; k = k + 1) begin
            if (k < mf_len)
                mf_sum = mf_sum + {{4{taps[k*SW+SW-1]}}, taps[k*SW +: SW]};
        end
    end

    // Output stage ahead of the buffer
    always @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            st_valid_r <= 1'b0;
            st_data_r <= {(SW+4){1'b0}};
        end else if (emit) begin
            st_valid_r <= 1'b1;
            st_data_r <= mf_sum;
        end else if (st_move) begin
            st_valid_r <= 1'b0;
        end
    end

    pair_buffer #(
        .W(SW + 4)
    ) out_buf (
        .CLK(CLK),
        .RST_B(RST_B),
        .S_DATA(st_data_r),
        .S_VALID(st_valid_r),
        .S_READY(buf_ready),
        .M_DATA(OUT_DATA),
        .M_VALID(OUT_VALID),
        .M_READY(OUT_READY)
    );

    // ------------
    // Signal detector
    // ------------
    wire [7:0] thr_run = cfg_flat[`IDX_THR_RUN*8 +: 8];
    wire [7:0] thr_wake = cfg_flat[`IDX_THR_WAKE*8 +: 8];
    wire [7:0] detector_low_threshold = cfg_flat[`IDX_THR_LOW*8 +: 8];
    wire [7:0] detector_threshold = wakeup ? thr_wake : thr_run;
    reg [4:0] ask_rng;
    wire [4:0] fsk_rng = {2'h0, fsk_range_factor, 1'b0} + 5'h02;
    wire [4:0] low_rng = {2'h0, low_range_factor, 1'b0} + 5'h02;

    // ASK range steps are irregular, so they come from a table
    always @* begin
        case (ask_range_factor)
            2'h0: ask_rng = `ASK_RNG_C0;
            2'h1: ask_rng = `ASK_RNG_C1;
            2'h2: ask_rng = `ASK_RNG_C2;
            default: ask_rng = `ASK_RNG_C3;
        endcase
    end

    wire [4:0] sel_rng = mode_ask ? ask_rng : fsk_rng;
    wire [23:0] thr_eff = {16'h0000, detector_threshold} << sel_rng;
    wire [23:0] low_eff = {16'h0000, detector_low_threshold} << low_rng;
    wire [SW-1:0] mag = scaled[SW-1] ? (~scaled + 1'b1) : scaled;
    wire [23:0] mag_ext = {{(24-SW){1'b0}}, mag};
    wire low_gated = (detector_selection == `DETECTOR_SELECTION_GATED);
    reg [7:0] signal_power_readout;

    // Decisions refresh once per decimated sample
    always @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            SIGNAL_DETECT <= 1'b0;
            LOW_LEVEL_DETECT <= 1'b0;
            signal_power_readout <= 8'h00;
        end else begin
            if (dump) begin
                SIGNAL_DETECT <= (mag_ext > thr_eff);
                signal_power_readout <= mag[SW-1:SW-8];
            end
            // Outside selection 11 the low threshold has no effect
            if (~low_gated)
                LOW_LEVEL_DETECT <= 1'b0;
            else if (dump)
                LOW_LEVEL_DETECT <= (mag_ext > low_eff);
        end
    end

    // Noise result gated by the low level only in selection 11
    always @(posedge CLK or negedge RST_B) begin
        if (!RST_B)
            NOISE_VALID <= 1'b0;
        else
            NOISE_VALID <= noise_raw & (~low_gated | LOW_LEVEL_DETECT);
    end

    // ------------
    // Slicer bandwidth
    // ------------
    // Unused codes hold the narrowest bandwidth rather than a wild value
    wire [2:0] bw_code = (slicer_manual_bw > `SLC_BW_LAST) ? `SLC_BW_LAST : slicer_manual_bw;
    wire [6:0] bw_base = {1'b0, bw_code, 3'h0} + 7'h08;
    always @(posedge CLK or negedge RST_B) begin
        if (!RST_B)
            SLICER_BW_DIV <= 11'h000;
        else
            SLICER_BW_DIV <= {4'h0, bw_base} << ({1'b0, slicer_bw_scaling} + 3'h1);
    end

    // ------------
    // Read port
    // ------------
    reg [7:0] rd_mux;
    integer j;

    // Unmapped addresses read zero
    always @* begin
        rd_mux = 8'h00;
        for (j = 0; j < `REG_COUNT; j = j + 1) begin
            if (ADDR == OFFS[j*8 +: 8])
                rd_mux = cfg_flat[j*8 +: 8];
        end
        if (ADDR == `OFS_SIGNAL_POWER_READOUT)
            rd_mux = signal_power_readout;
        if (ADDR == `OFS_DETECT_STATUS) begin
            rd_mux[`STS_SIGNAL] = SIGNAL_DETECT;
            rd_mux[`STS_LOW] = LOW_LEVEL_DETECT;
            rd_mux[`STS_NOISE] = NOISE_VALID;
        end
    end

    // Data stand only in the cycle after the strobe
    always @(posedge CLK or negedge RST_B) begin
        if (!RST_B)
            RD_DATA <= 8'h00;
        else if (RD_STB)
            RD_DATA <= rd_mux;
        else
            RD_DATA <= 8'h00;
    end

endmodule // baseband_decim_sigdet_config

`default_nettype wire

// file: hw/bbcfg_consts.vh
`ifndef BBCFG_CONSTS_VH
`define BBCFG_CONSTS_VH

// ------------
// Register map
// ------------
`define REG_ADDR_W 8
`define REG_COUNT 10
`define OFS_PREDECIMATION_FACTOR 8'h39
`define OFS_PREDECIMATION_SCALING_FSK 8'h3a
`define OFS_PREDECIMATION_SCALING_ASK 8'h3b
`define OFS_MATCHED_FILTER_CONTROL 8'h3c
`define OFS_RATE_CONVERTER_NCO_TUNE 8'h3d
`define OFS_EXTERNAL_SLICER_CONFIG 8'h3e
`define OFS_DETECTOR_THRESHOLD_RUN 8'h3f
`define OFS_DETECTOR_THRESHOLD_WAKEUP 8'h40
`define OFS_DETECTOR_THRESHOLD_LOW 8'h41
`define OFS_DETECTOR_RANGE_SELECT 8'h42
`define OFS_SIGNAL_POWER_READOUT 8'h50
`define OFS_DETECT_STATUS 8'h51

// Offsets, write masks and reset values, entry 0 in the low byte
`define REG_OFFSETS {8'h42, 8'h41, 8'h40, 8'h3f, 8'h3e, 8'h3d, 8'h3c, 8'h3b, 8'h3a, 8'h39}
`define REG_MASKS {8'h3f, 8'hff, 8'hff, 8'hff, 8'h1f, 8'hff, 8'h0f, 8'h3f, 8'h3f, 8'h7f}
`define REG_RESETS {8'h7f, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'h07, 8'h20, 8'h00, 8'h00}

// Entry numbers inside the register array
`define IDX_PDECF 0
`define IDX_SCFSK 1
`define IDX_SCASK 2
`define IDX_MFC 3
`define IDX_NCO 4
`define IDX_SLC 5
`define IDX_THR_RUN 6
`define IDX_THR_WAKE 7
`define IDX_THR_LOW 8
`define IDX_RSEL 9

// ------------
// Field positions
// ------------
`define DECIM_MSB 6
`define INTERP_BIT 5
`define PRESCALE_MSB 4
`define MFL_MSB 3
`define SLC_BW_MSB 2
`define SLC_SCA_MSB 4
`define SLC_SCA_LSB 3
`define ASK_RNG_MSB 5
`define ASK_RNG_LSB 4
`define FSK_RNG_MSB 3
`define FSK_RNG_LSB 2
`define LOW_RNG_MSB 1
`define LOW_RNG_LSB 0
`define STS_SIGNAL 0
`define STS_LOW 1
`define STS_NOISE 2

// ------------
// Coding constants
// ------------
`define SCALE_UNITY 5'h0a
`define SCALE_MAX 5'h17
`define ASK_RNG_C0 5'h06
`define ASK_RNG_C1 5'h07
`define ASK_RNG_C2 5'h0d
`define ASK_RNG_C3 5'h08
`define DETECTOR_SELECTION_GATED 2'h3
`define SLC_BW_LAST 3'h5
`define NCO_WRAP 9'h100

`endif

// file: hw/pair_buffer.v
`timescale 1ns/10ps
`default_nettype none

module pair_buffer #(
    parameter W = 20
) (
    input wire CLK,
    input wire RST_B,
    input wire [W-1:0] S_DATA,
    input wire S_VALID,
    output wire S_READY,
    output wire [W-1:0] M_DATA,
    output wire M_VALID,
    input wire M_READY
);

    reg [W-1:0] head_r;
    reg [W-1:0] tail_r;
    reg [1:0] cnt_r;
    wire push;
    wire pop;

    // Full at two entries, so a stalled reader back-pressures the source
    assign S_READY = (cnt_r != 2'h2);
    assign M_VALID = (cnt_r != 2'h0);
    assign M_DATA = head_r;
    assign push = S_VALID & S_READY;
    assign pop = M_VALID & M_READY;

    // Head always holds the oldest word
    always @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            head_r <= {W{1'b0}};
            tail_r <= {W{1'b0}};
            cnt_r <= 2'h0;
        end else begin
            if (pop) begin
                if (cnt_r == 2'h2)
                    head_r <= tail_r;
                else if (push)
                    head_r <= S_DATA;
            end else if (push) begin
                if (cnt_r == 2'h0)
                    head_r <= S_DATA;
                else
                    tail_r <= S_DATA;
            end
            if (push & ~pop)
                cnt_r <= cnt_r + 2'h1;
            else if (pop & ~push)
                cnt_r <= cnt_r - 2'h1;
        end
    end

endmodule // pair_buffer

`default_nettype wire

// file: test/adc_stream_model.sv
`timescale 1ns/10ps
`default_nettype none

// ------------
// Sample source with random gaps
// ------------
module adc_stream_model (
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic RUN,
    input wire logic [3:0] AMP,
    input wire logic IN_READY,
    output logic [15:0] IN_DATA,
    output logic IN_VALID
);
    // A sample stands until taken; idle data toggles so no stale word looks valid
    always @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            IN_VALID <= 1'b0;
            IN_DATA <= 16'h0000;
        end else if (!IN_VALID || IN_READY) begin
            if (RUN && ($urandom % 3 != 0)) begin
                IN_VALID <= 1'b1;
                IN_DATA <= $signed(16'($urandom)) >>> AMP;
            end else begin
                IN_VALID <= 1'b0;
                IN_DATA <= ~IN_DATA;
            end
        end
    end
endmodule // adc_stream_model

`default_nettype wire

// file: test/baseband_decim_sigdet_config_sva.sv
`timescale 1ns/10ps
`default_nettype none

// ------------
// Port-level checks
// ------------
module baseband_decim_sigdet_config_sva #(
    parameter SW = 16,
    parameter MF_MAX = 16
) (
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WR_DATA,
    input wire logic WR_STB,
    input wire logic RD_STB,
    input wire logic [7:0] RD_DATA,
    input wire logic [SW-1:0] IN_DATA,
    input wire logic IN_VALID,
    input wire logic IN_READY,
    input wire logic [SW+3:0] OUT_DATA,
    input wire logic OUT_VALID,
    input wire logic OUT_READY,
    input wire logic MODE_ASK,
    input wire logic WAKEUP,
    input wire logic [1:0] DETECTOR_SELECTION,
    input wire logic NOISE_DETECT,
    input wire logic SIGNAL_DETECT,
    input wire logic LOW_LEVEL_DETECT,
    input wire logic NOISE_VALID,
    input wire logic [10:0] SLICER_BW_DIV
);
    logic [7:0] slc_r;
    logic [1:0] age_r;

    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_B);

    // Holes in the map must read back as zero
    function automatic logic mapped(input logic [7:0] a);
        return (a >= 8'h39 && a <= 8'h42) || a == 8'h50 || a == 8'h51;
    endfunction

    // Unused manual codes behave as the narrowest setting
    function automatic logic [10:0] div_of(input logic [7:0] v);
        logic [10:0] bw;
        bw = (v[2:0] > 3'h5) ? 11'h006 : {8'h00, v[2:0]} + 11'h001;
        return (bw << 3) << v[4:3] << 1;
    endfunction

    // Last slicer write; age starts short so the reset edge itself is skipped
    always @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            slc_r <= 8'h02;
            age_r <= 2'h2;
        end else if (WR_STB && ADDR == 8'h3e) begin
            slc_r <= WR_DATA;
            age_r <= 2'h0;
        end else if (age_r != 2'h3) begin
            age_r <= age_r + 2'h1;
        end
    end

    // Pins pass two sync stages and one output register
    sequence sel_other; (DETECTOR_SELECTION != 2'h3)[*4]; endsequence
    sequence sel_gated; (DETECTOR_SELECTION == 2'h3)[*4]; endsequence
    sequence noise_open; (DETECTOR_SELECTION != 2'h3 && NOISE_DETECT)[*4]; endsequence

    chk_rd_idle: assert property (!$past(RD_STB) |-> RD_DATA == 8'h00)
        else $error("idle read data");
    chk_rd_hole: assert property (RD_STB && !mapped(ADDR) |=> RD_DATA == 8'h00)
        else $error("hole read");
    chk_rsel_fixed: assert property (RD_STB && ADDR == 8'h42 |=> RD_DATA[7:6] == 2'h1)
        else $error("range top bits");
    chk_low_gated: assert property (sel_other |-> !LOW_LEVEL_DETECT)
        else $error("low detect ungated");
    chk_noise_pass: assert property (noise_open |-> NOISE_VALID)
        else $error("noise not passed");
    chk_noise_block: assert property ((!NOISE_DETECT)[*4] |-> !NOISE_VALID)
        else $error("noise valid idle");
    chk_noise_gate: assert property (sel_gated ##0 NOISE_VALID |->
        LOW_LEVEL_DETECT || $past(LOW_LEVEL_DETECT))
        else $error("noise without low");
    chk_slc_div: assert property (age_r == 2'h3 |-> SLICER_BW_DIV == div_of(slc_r))
        else $error("slicer divisor");
    chk_out_hold: assert property (OUT_VALID && !OUT_READY |=> OUT_VALID && $stable(OUT_DATA))
        else $error("stall changed");
    chk_ready_full: assert property (!IN_READY |-> OUT_VALID)
        else $error("refused while empty");
endmodule // baseband_decim_sigdet_config_sva

bind baseband_decim_sigdet_config baseband_decim_sigdet_config_sva #(
    .SW(SW), .MF_MAX(MF_MAX)) chk_u (.*);

`default_nettype wire

// file: test/baseband_decim_sigdet_config_tb.sv
`timescale 1ns/10ps
`default_nettype none

module baseband_decim_sigdet_config_tb;
    logic clk, rst_b, wr_stb, rd_stb, in_valid, in_ready, out_valid, out_ready, lo_e;
    logic mode_ask, wakeup, noise_det, sig_det, low_det, noise_val, run, stall;
    logic [7:0] addr, wr_data, rd_data;
    logic [1:0] det_sel;
    logic [3:0] amp;
    logic [15:0] in_data;
    logic [19:0] out_data;
    logic [10:0] slc_div;
    logic [7:0] rf [8'h39:8'h42];
    logic [19:0] exp_q [$];
    int n_mismatch, n_checks, acc, lastmag, n_in, i, k, thr, low_thr;
    logic [6:0] grp_cnt = 7'h00; // Wraps like the hardware group counter
    logic [7:0] msk [8'h39:8'h42] = '{8'h7f, 8'h3f, 8'h3f, 8'h0f, 8'hff, 8'h1f, 8'hff,
        8'hff, 8'hff, 8'h3f};
    longint grp_sum, prev;
    longint hist [16];

    baseband_decim_sigdet_config #(.SW(16), .MF_MAX(16)) dut_u (
        .CLK(clk), .RST_B(rst_b), .ADDR(addr), .WR_DATA(wr_data), .WR_STB(wr_stb),
        .RD_STB(rd_stb), .RD_DATA(rd_data), .IN_DATA(in_data), .IN_VALID(in_valid),
        .IN_READY(in_ready), .OUT_DATA(out_data), .OUT_VALID(out_valid),
        .OUT_READY(out_ready), .MODE_ASK(mode_ask), .WAKEUP(wakeup),
        .DETECTOR_SELECTION(det_sel), .NOISE_DETECT(noise_det), .SIGNAL_DETECT(sig_det),
        .LOW_LEVEL_DETECT(low_det), .NOISE_VALID(noise_val), .SLICER_BW_DIV(slc_div));

    adc_stream_model src_u (.CLK(clk), .RST_B(rst_b), .RUN(run), .AMP(amp),
        .IN_READY(in_ready), .IN_DATA(in_data), .IN_VALID(in_valid));

    // ------------
    // Expectations
    // ------------
    function automatic int rng(input int ask, input logic [1:0] c);
        int t [4] = '{6, 7, 13, 8};
        return ask ? t[c] : 2 * (c + 1);
    endfunction

    function automatic int div_of(input int v);
        return (8 * ((v % 8 > 5) ? 6 : v % 8 + 1)) << (v / 8 + 1);
    endfunction

    // Datapath model, run once per accepted sample
    task automatic feed(input longint s);
        longint v;
        int code, n;
        grp_sum += s;
        if (grp_cnt != rf[8'h39]) begin
            grp_cnt++;
        end else begin
            code = mode_ask ? rf[8'h3b][4:0] : rf[8'h3a][4:0];
            code = (code > 23) ? 23 : code;
            v = (code >= 10) ? grp_sum <<< (code - 10) : grp_sum >>> (10 - code);
            v = (v > 32767) ? 32767 : ((v < -32768) ? -32768 : v);
            lastmag = (v < 0) ? -v : v;
            hist[15] = (mode_ask ? rf[8'h3b][5] : rf[8'h3a][5]) ? (v + prev) >>> 1 : v;
            prev = v;
            grp_sum = 0;
            grp_cnt = 0;
            if (acc < 256) begin
                acc += rf[8'h3d];
                for (n = 0; n < 15; n++) hist[n] = hist[n + 1];
                for (n = 0; n <= rf[8'h3c]; n++) v = (n == 0) ? hist[14] : v + hist[14 - n];
                exp_q.push_back(v[19:0]);
            end else begin
                acc -= 256;
            end
        end
    endtask

    // ------------
    // Bus and reporting
    // ------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic complete_run;
        $display("TB: %0d checks, %0d mismatches", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic done(input string name);
        $display("TB: test %s finished, %0d mismatches so far", name, n_mismatch);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wr_data <= d;
        wr_stb <= 1'b1;
        @(posedge clk);
        wr_stb <= 1'b0;
        if (a >= 8'h39 && a <= 8'h42) rf[a] = d & msk[a];
    endtask

    task automatic rd(input logic [7:0] a);
        logic [7:0] e;
        e = (a >= 8'h39 && a <= 8'h42) ? (rf[a] | ((a == 8'h42) ? 8'h40 : 8'h00)) : 8'h00;
        @(posedge clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clk);
        rd_stb <= 1'b0;
        #1 check(rd_data, e, "register read");
    endtask

    // Bounded run of n samples, then drain everything predicted
    task automatic stream(input int n, input string name);
        n_in = 0;
        run <= 1'b1;
        for (i = 0; i < 5000 && n_in < n; i++) @(posedge clk);
        run <= 1'b0;
        for (; i < 5000 && (in_valid || exp_q.size() > 0); i++) @(posedge clk);
        if (i >= 5000) begin
            check(0, 1, "stream timed out");
            complete_run;
        end
        done(name);
    endtask

    // Accepted samples feed the model; delivered words are compared in order
    always @(posedge clk) begin
        if (rst_b && in_valid && in_ready) begin
            feed($signed(in_data));
            n_in++;
        end
        if (rst_b && out_valid && out_ready) begin
            if (exp_q.size() == 0) check(1, 0, "unexpected output");
            else check(out_data, exp_q.pop_front(), "stream output");
        end
    end

    always @(posedge clk) out_ready <= !stall && ($urandom % 4 != 0);

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // ------------
    // Main sequence
    // ------------
    initial begin
        {rst_b, wr_stb, rd_stb, out_ready, mode_ask, wakeup, noise_det, run, stall} = 9'h000;
        {addr, wr_data, det_sel, amp} = 22'h000000;
        rf = '{8'h00, 8'h00, 8'h20, 8'h07, 8'h00, 8'h02, 8'h00, 8'h00, 8'h00, 8'h7f};
        void'($urandom(32'h59eabe20));
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge clk);
        #1 check(slc_div, 48, "slicer divisor at reset");
        for (k = 8'h39; k <= 8'h42; k++) rd(k[7:0]);
        done("reset values");
        wr(8'h3a, 8'h2a);
        wr(8'h3c, 8'h00);
        amp <= 4'h4;
        stream(40, "interpolation");
        wr(8'h3a, 8'h0a);
        wr(8'h39, 8'h01);
        wr(8'h3c, 8'h03);
        stream(60, "decimation");
        wr(8'h39, 8'h00);
        wr(8'h3c, 8'h0f);
        wr(8'h3d, 8'hff);
        stream(60, "rate converter");
        wr(8'h3d, 8'h00);
        wr(8'h3c, 8'h00);
        amp <= 4'h0;
        for (k = 0; k < 4; k++) begin
            wr(8'h3a, 8'(32'h1f170d00 >> (8 * k)));
            stream(20, "gain");
        end
        stall = 1'b1;
        run <= 1'b1;
        for (i = 0; i < 200 && in_ready; i++) @(posedge clk);
        #1 check(in_ready, 0, "input refused when buffer full");
        stall = 1'b0;
        stream(10, "fill and drain");
        for (k = 8'h38; k <= 8'h43; k++) begin
            wr(k[7:0], 8'($urandom));
            rd(k[7:0]);
        end
        done("register access");
        for (k = 0; k < 32; k++) begin
            wr(8'h3e, k[7:0]);
            repeat (3) @(posedge clk);
            #1 check(slc_div, div_of(k), "slicer divisor");
        end
        done("slicer");
        wr(8'h39, 8'h00);
        wr(8'h3a, 8'h0a);
        wr(8'h3b, 8'h0a);
        wr(8'h3d, 8'h00);
        for (k = 0; k < 8; k++) begin
            wr(8'h3f, 8'($urandom));
            wr(8'h40, 8'($urandom));
            wr(8'h41, 8'($urandom));
            wr(8'h42, 8'($urandom));
            mode_ask <= k[0];
            det_sel <= k[2:1];
            wakeup <= 1'($urandom);
            noise_det <= 1'($urandom);
            amp <= 4'($urandom % 8);
            repeat (4) @(posedge clk);
            stream(6, "detector");
            repeat (5) @(posedge clk);
            thr = rf[wakeup ? 8'h40 : 8'h3f] << rng(mode_ask,
                mode_ask ? rf[8'h42][5:4] : rf[8'h42][3:2]);
            low_thr = rf[8'h41] << rng(0, rf[8'h42][1:0]);
            lo_e = det_sel == 2'h3 && lastmag > low_thr;
            #1 check(sig_det, lastmag > thr, "signal detect");
            check(low_det, lo_e, "low level detect");
            check(noise_val, noise_det && (det_sel != 2'h3 || lo_e), "noise valid");
        end
        complete_run;
    end
endmodule // baseband_decim_sigdet_config_tb

`default_nettype wire
